// >>> paop_pkg.sv
// Shared constants for the converter output port and its capture logic
package paop_pkg;
   // Data word
   localparam int PAOP_BITS = 10;
   localparam int PAOP_STAGES = 9;
   localparam int PAOP_LATENCY = 5;
   localparam logic [9:0] PAOP_MID_CODE = 10'h200;
   localparam logic [9:0] PAOP_MAX_CODE = 10'h3ff;
   // Residue arithmetic, full scale is +/- RES_HALF
   localparam int PAOP_RES_W = 11;
   localparam int PAOP_ACC_W = 12;
   localparam int PAOP_RES_HALF = 512;
   localparam int PAOP_RES_QTR = 128;
   localparam int PAOP_LAST_SHIFT = 8;
   // Analog input in millivolts
   localparam int PAOP_MV_W = 12;
   localparam int PAOP_SPAN_2V_MV = 2000;
   localparam int PAOP_SPAN_1V_MV = 1000;
   localparam int PAOP_CODES = 1024;
   // Capture side
   localparam int PAOP_DISCARD = 5;
   localparam int PAOP_FIFO_DEPTH = 32;
   localparam int PAOP_LVL_W = 6;
   localparam logic [7:0] PAOP_HALF_DIV_RST = 8'h02;
   // Register offsets
   localparam logic [7:0] PAOP_REG_CTRL = 8'h00;
   localparam logic [7:0] PAOP_REG_STAT = 8'h04;
   localparam logic [7:0] PAOP_REG_DATA = 8'h08;
   localparam logic [7:0] PAOP_REG_DIV = 8'h0c;
   // Control fields
   localparam int PAOP_CTRL_W = 7;
   localparam int PAOP_C_RUN = 0;
   localparam int PAOP_C_PD = 1;
   localparam int PAOP_C_RANGE = 2;
   localparam int PAOP_C_REFEXT = 3;
   localparam int PAOP_C_OUTEN = 4;
   localparam int PAOP_C_TWOS = 5;
   localparam int PAOP_C_FLOAT = 6;
   localparam logic [6:0] PAOP_CTRL_RST = 7'h14;
   // Status fields
   localparam int PAOP_S_EMPTY = 0;
   localparam int PAOP_S_FULL = 1;
   localparam int PAOP_S_PRIMING = 2;
   localparam int PAOP_S_LVL = 8;
   localparam int PAOP_D_VALID = 31;
endpackage : paop_pkg

// >>> paop_if.sv
// Pin-level link between converter and capture logic, with pin pulls
interface paop_if;
   import paop_pkg::*;
   logic conv_clk;
   logic power_down_request;
   logic range_select_drv;
   logic range_select_oe;
   logic reference_source_select_drv;
   logic reference_source_select_oe;
   logic output_drive_enable_n_drv;
   logic output_drive_enable_n_oe;
   logic [PAOP_BITS-1:0] sample_word;
   logic sample_word_oe;
   // Levels seen on the wires
   logic range_select;
   logic reference_source_select;
   logic output_drive_enable_n;
   // Weak pull-ups on the static selects
   assign range_select = range_select_oe ? range_select_drv : 1'b1;
   assign reference_source_select =
      reference_source_select_oe ? reference_source_select_drv : 1'b1;
   // Weak pull-down on the output enable
   assign output_drive_enable_n =
      output_drive_enable_n_oe ? output_drive_enable_n_drv : 1'b0;
   modport dev (
      input conv_clk,
      input power_down_request,
      input range_select,
      input reference_source_select,
      input output_drive_enable_n,
      output sample_word,
      output sample_word_oe
   );
   modport cap (
      output conv_clk,
      output power_down_request,
      output range_select_drv,
      output range_select_oe,
      output reference_source_select_drv,
      output reference_source_select_oe,
      output output_drive_enable_n_drv,
      output output_drive_enable_n_oe,
      input sample_word,
      input sample_word_oe
   );
endinterface : paop_if

// >>> paop_adc.sv
// Converter end: sampling, nine-stage pipeline, correction, output drive
// Function
// - Ten-bit parallel word, top bit first
// - Enable high floats data, low drives
// - Output enable weakly pulled low
// - Power-down level stops conversion
// - New data valid at convert clock rise
// - Result appears five convert cycles later
// - Range high gives 2 V, low 1 V
// - Reference high external, low internal
// - Nine stages merged by error correction
// - One sample per convert clock rise
// - Straight offset binary, mid-scale top bit
// - Range and reference weakly pulled high
module paop_adc
   import paop_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // Capture side pins
   paop_if.dev link,
   // Analog source, millivolts around common mode
   input wire logic signed [PAOP_MV_W-1:0] analog_mv,
   input wire logic [PAOP_MV_W-1:0] ext_span_mv,
   // Status
   output logic powered_down,
   output logic primed
);

   logic conv_q;
   logic rise;
   logic advance;
   logic pd_q;
   logic [2:0] fill_q;
   logic [PAOP_MV_W-1:0] span;
   logic signed [PAOP_RES_W-1:0] vin;
   logic signed [PAOP_RES_W-1:0] samp_q;
   logic signed [PAOP_RES_W-1:0] res_in [1:PAOP_STAGES];
   logic signed [PAOP_ACC_W-1:0] acc_in [1:PAOP_STAGES];
   logic signed [PAOP_RES_W-1:0] res_out [1:PAOP_STAGES-1];
   logic signed [PAOP_ACC_W-1:0] acc_out [1:PAOP_STAGES-1];
   logic signed [PAOP_ACC_W-1:0] code;
   logic [PAOP_BITS-1:0] word_q;

   // Convert clock rise seen on the system clock
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         conv_q <= 1'b0;
      else
         conv_q <= link.conv_clk;
   end

   assign rise = link.conv_clk & ~conv_q;
   // Pipeline moves on every rise unless powered down
   assign advance = rise & ~link.power_down_request;

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         pd_q <= 1'b0;
      else
         pd_q <= link.power_down_request;
   end

   assign powered_down = pd_q;

   // Words leaving the pipeline are stale until it has refilled
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         fill_q <= 3'h0;
      else if (link.power_down_request)
         fill_q <= 3'h0;
      else if (advance && fill_q != 3'(PAOP_LATENCY))
         fill_q <= fill_q + 3'h1;
   end

   assign primed = (fill_q == 3'(PAOP_LATENCY));

   // Full-scale span from the selects, which rest at their pulled levels
   always_comb
   begin
      if (link.reference_source_select)
      begin
         if (ext_span_mv == '0)
            span = PAOP_MV_W'(1);
         else
            span = ext_span_mv;
      end
      else if (link.range_select)
         span = PAOP_MV_W'(PAOP_SPAN_2V_MV);
      else
         span = PAOP_MV_W'(PAOP_SPAN_1V_MV);
   end

   // Scale to +/- half scale and clip
   always_comb
   begin
      int scaled;
      scaled = (int'(analog_mv) * PAOP_CODES) / int'(span);
      if (scaled > PAOP_RES_HALF - 1)
         vin = PAOP_RES_W'(PAOP_RES_HALF - 1);
      else if (scaled < -PAOP_RES_HALF)
         vin = PAOP_RES_W'(-PAOP_RES_HALF);
      else
         vin = PAOP_RES_W'(scaled);
   end

   // Track-and-hold, one sample per rise
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         samp_q <= '0;
      else if (advance)
         samp_q <= vin;
   end

   assign res_in[1] = samp_q;
   assign acc_in[1] = '0;

   // Eight redundant stages, registered after every second one
   for (genvar k = 1; k < PAOP_STAGES; k++)
   begin : g_stage
      localparam int WT = 1 << (PAOP_STAGES - k);
      logic signed [PAOP_ACC_W-1:0] dbl;

      assign dbl = {res_in[k][PAOP_RES_W-1], res_in[k]} <<< 1;

      always_comb
      begin
         if (res_in[k] >= PAOP_RES_W'(PAOP_RES_QTR))
         begin
            res_out[k] = PAOP_RES_W'(dbl - PAOP_ACC_W'(PAOP_RES_HALF));
            acc_out[k] = acc_in[k] + PAOP_ACC_W'(WT);
         end
         else if (res_in[k] < -PAOP_RES_W'(PAOP_RES_QTR))
         begin
            res_out[k] = PAOP_RES_W'(dbl + PAOP_ACC_W'(PAOP_RES_HALF));
            acc_out[k] = acc_in[k] - PAOP_ACC_W'(WT);
         end
         else
         begin
            res_out[k] = PAOP_RES_W'(dbl);
            acc_out[k] = acc_in[k];
         end
      end

      if (k % 2 == 0)
      begin : g_reg
         always_ff @(posedge sys_clk or negedge arst_n)
         begin
            if (!arst_n)
            begin
               res_in[k+1] <= '0;
               acc_in[k+1] <= '0;
            end
            else if (advance)
            begin
               res_in[k+1] <= res_out[k];
               acc_in[k+1] <= acc_out[k];
            end
         end
      end
      else
      begin : g_pass
         assign res_in[k+1] = res_out[k];
         assign acc_in[k+1] = acc_out[k];
      end
   end

   // Final two-bit stage and error correction sum, offset to mid-scale
   always_comb
   begin
      logic signed [PAOP_RES_W-1:0] d_last;
      d_last = res_in[PAOP_STAGES] >>> PAOP_LAST_SHIFT;
      code = acc_in[PAOP_STAGES]
           + {{(PAOP_ACC_W-PAOP_RES_W){d_last[PAOP_RES_W-1]}}, d_last}
           + PAOP_ACC_W'(PAOP_MID_CODE);
   end

   // Output word, fifth register after the sample
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         word_q <= PAOP_MID_CODE;
      else if (advance)
      begin
         if (code < 0)
            word_q <= '0;
         else if (code > PAOP_ACC_W'(PAOP_MAX_CODE))
            word_q <= PAOP_MAX_CODE;
         else
            word_q <= code[PAOP_BITS-1:0];
      end
   end

   // Top pin carries the most significant bit
   assign link.sample_word = word_q;
   // Enable is active low; undriven reads low through the pull
   assign link.sample_word_oe = ~link.output_drive_enable_n;

endmodule : paop_adc

// >>> paop_capture.sv
// Capture end: convert clock, control pins, word capture, FIFO, APB registers
module paop_fifo #(
   parameter int W = 10,
   parameter int DEPTH = 32,
   parameter int LW = 6
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data,
   output logic [LW-1:0] level
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;

   assign level = LW'(wr_q - rd_q);
   assign in_ready = (level != LW'(DEPTH));
   assign out_valid = (wr_q != rd_q);
   assign out_data = mem_q[rd_q[AW-1:0]];

   always_ff @(posedge sys_clk)
   begin
      if (in_valid && in_ready)
         mem_q[wr_q[AW-1:0]] <= in_data;
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wr_q <= '0;
         rd_q <= '0;
      end
      else
      begin
         if (in_valid && in_ready)
            wr_q <= wr_q + 1'b1;
         if (out_valid && out_ready)
            rd_q <= rd_q + 1'b1;
      end
   end
endmodule : paop_fifo

module paop_capture
   import paop_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // Converter pins
   paop_if.cap link,
   // APB slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   logic [PAOP_CTRL_W-1:0] ctrl_q;
   logic [7:0] div_q;
   logic [7:0] cnt_q;
   logic conv_q;
   logic tick;
   logic cap_rise;
   logic [2:0] disc_q;
   logic push;
   logic in_ready;
   logic out_valid;
   logic pop;
   logic [PAOP_BITS-1:0] out_data;
   logic [PAOP_BITS-1:0] word;
   logic [PAOP_LVL_W-1:0] level;
   logic [31:0] rdata_q;
   logic wr_acc;

   // Divided convert clock; a full FIFO stalls it
   assign tick = ctrl_q[PAOP_C_RUN] & in_ready & (cnt_q >= div_q - 8'h01);
   assign cap_rise = tick & ~conv_q;

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt_q <= 8'h00;
         conv_q <= 1'b0;
      end
      else if (!ctrl_q[PAOP_C_RUN])
         cnt_q <= 8'h00;
      else if (tick)
      begin
         cnt_q <= 8'h00;
         conv_q <= ~conv_q;
      end
      else if (in_ready)
         cnt_q <= cnt_q + 8'h01;
   end

   // Drop the first five words latched after start or wake
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         disc_q <= 3'(PAOP_DISCARD);
      else if (!ctrl_q[PAOP_C_RUN] || ctrl_q[PAOP_C_PD])
         disc_q <= 3'(PAOP_DISCARD);
      else if (cap_rise && disc_q != 3'h0)
         disc_q <= disc_q - 3'h1;
   end

   // Word held since the previous rise is latched at this rise
   assign push = cap_rise & (disc_q == 3'h0) & link.sample_word_oe;
   assign word = ctrl_q[PAOP_C_TWOS] ? (link.sample_word ^ PAOP_MID_CODE)
                                     : link.sample_word;

   paop_fifo #(.W(PAOP_BITS), .DEPTH(PAOP_FIFO_DEPTH), .LW(PAOP_LVL_W)) paop_fifo_inst (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .in_valid(push),
      .in_ready(in_ready),
      .in_data(word),
      .out_valid(out_valid),
      .out_ready(pop),
      .out_data(out_data),
      .level(level)
   );

   // Pins; float leaves every pulled pin undriven
   assign link.conv_clk = conv_q;
   assign link.power_down_request = ctrl_q[PAOP_C_PD];
   assign link.range_select_drv = ctrl_q[PAOP_C_RANGE];
   assign link.range_select_oe = ~ctrl_q[PAOP_C_FLOAT];
   assign link.reference_source_select_drv = ctrl_q[PAOP_C_REFEXT];
   assign link.reference_source_select_oe = ~ctrl_q[PAOP_C_FLOAT];
   assign link.output_drive_enable_n_drv = ~ctrl_q[PAOP_C_OUTEN];
   assign link.output_drive_enable_n_oe = ~ctrl_q[PAOP_C_FLOAT];

   // APB, zero wait, data registered in the setup cycle
   assign pready = 1'b1;
   assign pslverr = psel & penable & (paddr != PAOP_REG_CTRL) & (paddr != PAOP_REG_STAT)
                  & (paddr != PAOP_REG_DATA) & (paddr != PAOP_REG_DIV);
   assign prdata = rdata_q;
   assign wr_acc = psel & penable & pwrite;
   // Pop only the word whose valid bit the setup cycle returned
   assign pop = psel & penable & ~pwrite & (paddr == PAOP_REG_DATA) & rdata_q[PAOP_D_VALID];

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ctrl_q <= PAOP_CTRL_RST;
         div_q <= PAOP_HALF_DIV_RST;
      end
      else if (wr_acc && paddr == PAOP_REG_CTRL)
         ctrl_q <= pwdata[PAOP_CTRL_W-1:0];
      else if (wr_acc && paddr == PAOP_REG_DIV)
         div_q <= (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         rdata_q <= 32'h0;
      else if (psel && !penable && !pwrite)
      begin
         rdata_q <= 32'h0;
         case (paddr)
            PAOP_REG_CTRL: rdata_q[PAOP_CTRL_W-1:0] <= ctrl_q;
            PAOP_REG_DIV: rdata_q[7:0] <= div_q;
            PAOP_REG_STAT:
            begin
               rdata_q[PAOP_S_EMPTY] <= ~out_valid;
               rdata_q[PAOP_S_FULL] <= ~in_ready;
               rdata_q[PAOP_S_PRIMING] <= (disc_q != 3'h0);
               rdata_q[PAOP_S_LVL +: PAOP_LVL_W] <= level;
            end
            PAOP_REG_DATA:
            begin
               rdata_q[PAOP_D_VALID] <= out_valid;
               rdata_q[PAOP_BITS-1:0] <= out_data;
            end
            default: rdata_q <= 32'h0;
         endcase
      end
   end
endmodule : paop_capture

// >>> paop_sva.sv
// Link checks between converter end and capture end
module paop_sva
   import paop_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // Capture-driven pins
   input wire logic conv_clk,
   input wire logic power_down_request,
   input wire logic range_select_oe,
   input wire logic reference_source_select_oe,
   input wire logic output_drive_enable_n_oe,
   // Resolved levels
   input wire logic range_select,
   input wire logic reference_source_select,
   input wire logic output_drive_enable_n,
   // Converter outputs
   input wire logic [PAOP_BITS-1:0] sample_word,
   input wire logic sample_word_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);
   // Convert clock rose one or two edges back
   sequence rise_back;
      ($past(conv_clk) && !$past(conv_clk, 2)) || ($past(conv_clk, 2) && !$past(conv_clk, 3));
   endsequence
   sequence pd_held;
      power_down_request [*5];
   endsequence
   oe_tracks_a: assert property (sample_word_oe == !output_drive_enable_n)
      else $error("data drive does not follow the enable pin");
   oe_edge_a: assert property ($changed(output_drive_enable_n)
      |-> $changed(sample_word_oe))
      else $error("data drive lags the enable pin");
   enable_pull_a: assert property (!output_drive_enable_n_oe |-> !output_drive_enable_n)
      else $error("released enable pin not pulled low");
   range_pull_a: assert property (!range_select_oe |-> range_select)
      else $error("released range pin not pulled high");
   ref_pull_a: assert property (!reference_source_select_oe |-> reference_source_select)
      else $error("released reference pin not pulled high");
   word_on_rise_a: assert property ($changed(sample_word) |-> rise_back)
      else $error("data word changed away from a convert rise");
   word_hold_a: assert property ($changed(sample_word) |=> $stable(sample_word))
      else $error("data word changed on two edges in a row");
   pd_freeze_a: assert property (pd_held |-> $stable(sample_word))
      else $error("data word moved during power-down");
endmodule : paop_sva

// >>> pipelined_adc_output_port_tb_top.sv
// Self-checking bench for converter end and capture end joined by the link
module pipelined_adc_output_port_tb_top
   import paop_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk;
   logic arst_n;
   logic signed [PAOP_MV_W-1:0] analog_mv;
   logic [PAOP_MV_W-1:0] ext_span_mv;
   logic powered_down;
   logic primed;
   logic [7:0] paddr;
   logic psel;
   logic penable;
   logic pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [31:0] rd;
   logic err;
   logic prev_conv = 1'b0;
   int n_errors = 0;
   int compares = 0;
   int n_rises = 0;
   int cycles = 0;
   logic [6:0] m_ctl [5] = '{7'h15, 7'h11, 7'h11, 7'h19, 7'h41};
   logic [11:0] m_mv [5] = '{12'hc18, 12'h0fa, 12'h258, 12'h1f4, 12'he0c};
   logic [9:0] m_code [5] = '{10'h000, 10'h300, 10'h3ff, 10'h280, 10'h180};
   paop_if paop_if_inst ();
   paop_adc paop_adc_inst (.sys_clk(sys_clk), .arst_n(arst_n), .link(paop_if_inst.dev),
      .analog_mv(analog_mv), .ext_span_mv(ext_span_mv), .powered_down(powered_down),
      .primed(primed));
   paop_capture paop_capture_inst (.sys_clk(sys_clk), .arst_n(arst_n),
      .link(paop_if_inst.cap), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   paop_sva paop_sva_inst (.sys_clk(sys_clk), .arst_n(arst_n),
      .conv_clk(paop_if_inst.conv_clk), .power_down_request(paop_if_inst.power_down_request),
      .range_select_oe(paop_if_inst.range_select_oe),
      .reference_source_select_oe(paop_if_inst.reference_source_select_oe),
      .output_drive_enable_n_oe(paop_if_inst.output_drive_enable_n_oe),
      .range_select(paop_if_inst.range_select),
      .reference_source_select(paop_if_inst.reference_source_select),
      .output_drive_enable_n(paop_if_inst.output_drive_enable_n),
      .sample_word(paop_if_inst.sample_word), .sample_word_oe(paop_if_inst.sample_word_oe));
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // Convert rise counter and hang guard
   always @(posedge sys_clk)
   begin
      prev_conv <= paop_if_inst.conv_clk;
      cycles <= cycles + 1;
      if (paop_if_inst.conv_clk === 1'b1 && prev_conv === 1'b0)
         n_rises <= n_rises + 1;
      if (cycles == 8000)
      begin
         n_errors++;
         $display("unexpected at %0t: run timed out", $time);
         report_and_stop();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1)
         @(posedge sys_clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wreg
   task automatic rreg(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask : rreg
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : cyc
   task automatic wait_rises(input int n);
      int t;
      t = n_rises + n;
      while (n_rises < t)
         @(posedge sys_clk);
   endtask : wait_rises
   task automatic drain();
      rd = 32'h8000_0000;
      while (rd[PAOP_D_VALID] === 1'b1)
         rreg(PAOP_REG_DATA);
   endtask : drain
   task automatic t_reset();
      chk(paop_if_inst.sample_word, PAOP_MID_CODE, "reset word");
      chk(paop_if_inst.sample_word_oe, 1'b1, "drive at reset");
      rreg(PAOP_REG_CTRL);
      chk(rd, 32'h14, "ctrl reset");
      rreg(PAOP_REG_DIV);
      chk(rd, 32'h2, "div reset");
      wreg(PAOP_REG_DIV, 32'h0);
      rreg(PAOP_REG_DIV);
      chk(rd, 32'h1, "div floor");
      wreg(PAOP_REG_DIV, 32'h2);
      rreg(8'h10);
      chk(err, 1'b1, "unmapped error");
      chk(rd, 32'h0, "unmapped data");
      $display("test reset done");
   endtask : t_reset
   task automatic t_latency();
      analog_mv <= 12'h000;
      wreg(PAOP_REG_CTRL, 32'h15);
      wait_rises(8);
      analog_mv <= 12'h1f4;
      wait_rises(5);
      cyc(1);
      chk(paop_if_inst.sample_word, 10'h200, "old sample");
      wait_rises(1);
      cyc(1);
      chk(paop_if_inst.sample_word, 10'h300, "new sample");
      drain();
      $display("test latency done");
   endtask : t_latency
   task automatic t_modes();
      ext_span_mv <= 12'hfa0;
      for (int i = 0; i < 5; i++)
      begin
         wreg(PAOP_REG_CTRL, {25'h0, m_ctl[i]});
         analog_mv <= m_mv[i];
         wait_rises(8);
         cyc(1);
         chk(paop_if_inst.sample_word, m_code[i], "mode code");
         drain();
      end
      chk(paop_if_inst.range_select, 1'b1, "range pull");
      chk(paop_if_inst.output_drive_enable_n, 1'b0, "enable pull");
      $display("test modes done");
   endtask : t_modes
   task automatic t_fifo();
      int s;
      analog_mv <= 12'h1f4;
      wreg(PAOP_REG_CTRL, 32'h35);
      wait_rises(8);
      drain();
      rd = 32'h0;
      while (rd[PAOP_S_FULL] !== 1'b1)
         rreg(PAOP_REG_STAT);
      chk(rd[13:8], 6'h20, "full level");
      s = n_rises;
      cyc(40);
      chk(n_rises, s, "stalled while full");
      wreg(PAOP_REG_CTRL, 32'h34);
      for (int i = 0; i < PAOP_FIFO_DEPTH; i++)
      begin
         rreg(PAOP_REG_DATA);
         chk(rd, 32'h8000_0100, "twos word");
      end
      rreg(PAOP_REG_DATA);
      chk(rd[PAOP_D_VALID], 1'b0, "empty read");
      $display("test fifo done");
   endtask : t_fifo
   task automatic t_power();
      wreg(PAOP_REG_CTRL, 32'h05);
      cyc(2);
      chk(paop_if_inst.sample_word_oe, 1'b0, "floated");
      wait_rises(10);
      rreg(PAOP_REG_STAT);
      chk(rd[PAOP_S_EMPTY], 1'b1, "floated words dropped");
      wreg(PAOP_REG_CTRL, 32'h17);
      cyc(3);
      chk(powered_down, 1'b1, "pd entered");
      analog_mv <= 12'h000;
      cyc(60);
      chk(paop_if_inst.sample_word, 10'h300, "frozen word");
      wreg(PAOP_REG_CTRL, 32'h15);
      rreg(PAOP_REG_STAT);
      chk(rd[PAOP_S_PRIMING], 1'b1, "priming after wake");
      chk(powered_down, 1'b0, "pd left");
      chk(primed, 1'b0, "not primed");
      wait_rises(7);
      cyc(1);
      chk(primed, 1'b1, "primed");
      chk(paop_if_inst.sample_word, 10'h200, "resumed word");
      $display("test power done");
   endtask : t_power
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop
   initial
   begin
      arst_n = 1'b0;
      analog_mv = 12'h000;
      ext_span_mv = 12'h7d0;
      paddr = 8'h00;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      pwdata = 32'h0;
      repeat (5) @(posedge sys_clk);
      arst_n <= 1'b1;
      t_reset();
      t_latency();
      t_modes();
      t_fifo();
      t_power();
      report_and_stop();
   end
endmodule : pipelined_adc_output_port_tb_top
